// file: verilog/medc_ctrl.sv
// Datapath occupancy, energy efficient and duplex control with a Wishbone slave
`timescale 1ns/1ps
`default_nettype none

module medc_ctrl
(
   input  wire logic        clk,                    // System clock, 10 MHz
   input  wire logic        rst_n,                  // Asynchronous reset, active low
   // Classic Wishbone slave
   input  wire logic        wb_cyc_i,               // Cycle in progress
   input  wire logic        wb_stb_i,               // Strobe
   input  wire logic        wb_we_i,                // Write when high
   input  wire logic [11:0] wb_adr_i,               // Byte address
   input  wire logic [3:0]  wb_sel_i,               // Byte enables
   input  wire logic [31:0] wb_dat_i,               // Write data
   output logic      [31:0] wb_dat_o,               // Read data
   output logic             wb_ack_o,               // Acknowledge
   // Occupancy counts from the FIFO controllers, same clock
   input  wire logic [15:0] usb_out_fifo_bytes,     // Bytes held in the USB out FIFO
   input  wire logic [15:0] rx_frame_fifo_bytes,    // Bytes held in the receive frame FIFO
   input  wire logic [15:0] usb_in_fifo_bytes,      // Bytes held in the USB in FIFO
   input  wire logic [15:0] tx_frame_fifo_bytes,    // Bytes held in the transmit frame FIFO
   // MAC side, same clock
   input  wire logic        speed_100m,             // MAC runs at 100 Mbps
   input  wire logic        tx_lpi_request,         // Transmit path asks for LPI
   input  wire logic        rx_lpi_indication,      // Receive decoder sees LPI
   // PHY duplex indicator pin, asynchronous
   input  wire logic        full_duplex_indicator,  // PHY duplex level
   // Results
   output logic             full_duplex,            // Active duplex mode, high is full
   output logic             tx_lpi_active,          // Transmit LPI signalled
   output logic             gtx_clk_halt,           // Stop the transmit clock toward PHY
   output logic             rx_lpi_seen,            // Receive LPI decoded
   output logic             transmitter_on,         // Transmitter enable to MAC
   output logic             receiver_on             // Receiver enable to MAC
);

   // All state of the block in one record
   typedef struct packed
   {
      logic                             ack;         // Bus acknowledge
      logic [31:0]                      rdata;       // Bus read data
      logic [31:0]                      rx_usage;    // Sampled receive occupancy
      logic [31:0]                      tx_usage;    // Sampled transmit occupancy
      logic                             clk_halt;    // lpi_tx_clock_halt_enable
      logic                             eee_on;      // energy_efficient_on
      logic                             auto_exit;   // lpi_auto_exit_enable
      logic                             dpx_pol;     // duplex_indicator_polarity
      logic                             auto_dpx;    // Automatic duplex detection
      logic                             dpx_sel;     // duplex_select
      logic                             tx_on;       // transmitter_on
      logic                             rx_on;       // receiver_on
      logic                             protect;     // Reset protection
      logic [medc_pkg::DELAY_W-1:0]     exit_delay;  // lpi_auto_exit_delay
      medc_pkg::medc_lpi_t              lpi_state;   // Transmit LPI sequencer
      logic [medc_pkg::DELAY_W-1:0]     lpi_count;   // Cycles since LPI began
      logic                             dpx_sync1;   // Indicator synchroniser, first stage
      logic                             dpx_sync2;   // Indicator synchroniser, second stage
      logic                             full_dpx;    // Registered duplex result
      logic                             tx_lpi;      // Registered transmit LPI
      logic                             gtx_halt;    // Registered clock halt
      logic                             rx_lpi;      // Registered receive LPI
   } medc_state_t;

   medc_state_t s;       // Current state
   medc_state_t next_s;  // Next state

   // Outputs straight from the state flops
   assign wb_ack_o       = s.ack;
   assign wb_dat_o       = s.rdata;
   assign full_duplex    = s.full_dpx;
   assign tx_lpi_active  = s.tx_lpi;
   assign gtx_clk_halt   = s.gtx_halt;
   assign rx_lpi_seen    = s.rx_lpi;
   assign transmitter_on = s.tx_on;
   assign receiver_on    = s.rx_on;

   // Next state of every field
   always_comb
   begin
      logic        req;        // New bus request this cycle
      logic        wr;         // Write request
      logic [31:0] ctrl_rd;    // Control register read image
      logic        detected;   // Duplex seen on the indicator
      logic        lpi_req;    // Qualified LPI request
      logic [16:0] rx_sum;     // Receive total before truncation
      logic [16:0] tx_sum;     // Transmit total before truncation

      next_s   = s;
      req      = wb_cyc_i && wb_stb_i && !s.ack;
      wr       = req && wb_we_i;
      ctrl_rd  = 32'h0000_0000;
      detected = 1'h0;
      lpi_req  = 1'h0;
      rx_sum   = 17'h0_0000;
      tx_sum   = 17'h0_0000;

      // Occupancy sampled every cycle; totals wrap at 16 bits like the counters feeding them
      rx_sum = {1'h0, usb_out_fifo_bytes} + {1'h0, rx_frame_fifo_bytes};
      tx_sum = {1'h0, usb_in_fifo_bytes} + {1'h0, tx_frame_fifo_bytes};
      next_s.rx_usage = {rx_sum[15:0], usb_out_fifo_bytes};
      next_s.tx_usage = {tx_sum[15:0], usb_in_fifo_bytes};

      // Control register image; unlisted bits stay zero
      ctrl_rd[medc_pkg::BIT_CLK_HALT]  = s.clk_halt;
      ctrl_rd[medc_pkg::BIT_EEE_ON]    = s.eee_on;
      ctrl_rd[medc_pkg::BIT_AUTO_EXIT] = s.auto_exit;
      ctrl_rd[medc_pkg::BIT_DPX_POL]   = s.dpx_pol;
      ctrl_rd[medc_pkg::BIT_AUTO_DPX]  = s.auto_dpx;
      ctrl_rd[medc_pkg::BIT_DPX_SEL]   = s.dpx_sel;
      ctrl_rd[medc_pkg::BIT_TX_ON]     = s.tx_on;
      ctrl_rd[medc_pkg::BIT_RX_ON]     = s.rx_on;

      // Acknowledge one cycle after the request, drop it the cycle after
      next_s.ack   = req;
      next_s.rdata = 32'h0000_0000;
      if (req && !wb_we_i)
      begin
         // Read mux; unmapped addresses answer zero
         case (wb_adr_i)
            medc_pkg::ADDR_RX_USAGE:   next_s.rdata = s.rx_usage;
            medc_pkg::ADDR_TX_USAGE:   next_s.rdata = s.tx_usage;
            medc_pkg::ADDR_MAC_CTRL:   next_s.rdata = ctrl_rd;
            medc_pkg::ADDR_EXIT_DELAY: next_s.rdata = {8'h00, s.exit_delay};
            medc_pkg::ADDR_MISC_CTRL:  next_s.rdata = {31'h0000_0000, s.protect};
            default:                   next_s.rdata = 32'h0000_0000;
         endcase
      end

      // Control register write, per byte lane; usage registers take no write
      if (wr && wb_adr_i == medc_pkg::ADDR_MAC_CTRL)
      begin
         // Byte 2 holds the energy efficient controls
         if (wb_sel_i[2])
         begin
            next_s.clk_halt  = wb_dat_i[medc_pkg::BIT_CLK_HALT];
            next_s.eee_on    = wb_dat_i[medc_pkg::BIT_EEE_ON];
            next_s.auto_exit = wb_dat_i[medc_pkg::BIT_AUTO_EXIT];
         end
         // Byte 1 holds the duplex controls
         if (wb_sel_i[1])
         begin
            next_s.dpx_pol  = wb_dat_i[medc_pkg::BIT_DPX_POL];
            next_s.auto_dpx = wb_dat_i[medc_pkg::BIT_AUTO_DPX];
         end
         // Byte 0 holds duplex select and the path enables
         if (wb_sel_i[0])
         begin
            next_s.dpx_sel = wb_dat_i[medc_pkg::BIT_DPX_SEL];
            next_s.tx_on   = wb_dat_i[medc_pkg::BIT_TX_ON];
            next_s.rx_on   = wb_dat_i[medc_pkg::BIT_RX_ON];
         end
      end

      // Auto exit delay write, three low byte lanes
      if (wr && wb_adr_i == medc_pkg::ADDR_EXIT_DELAY)
      begin
         if (wb_sel_i[0])
            next_s.exit_delay[7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1])
            next_s.exit_delay[15:8] = wb_dat_i[15:8];
         if (wb_sel_i[2])
            next_s.exit_delay[23:16] = wb_dat_i[23:16];
      end

      // Protection bit and soft reset share byte 0
      if (wr && wb_adr_i == medc_pkg::ADDR_MISC_CTRL && wb_sel_i[0])
      begin
         next_s.protect = wb_dat_i[medc_pkg::BIT_PROTECT];
         // Soft reset uses the protection value already held, not the one written with it
         if (wb_dat_i[medc_pkg::BIT_SOFT_RESET] && !s.protect)
         begin
            next_s.clk_halt   = medc_pkg::RST_CLK_HALT;
            next_s.eee_on     = medc_pkg::RST_EEE_ON;
            next_s.auto_exit  = medc_pkg::RST_AUTO_EXIT;
            next_s.dpx_pol    = medc_pkg::RST_DPX_POL;
            next_s.auto_dpx   = medc_pkg::RST_AUTO_DPX;
            next_s.dpx_sel    = medc_pkg::RST_DPX_SEL;
            next_s.tx_on      = medc_pkg::RST_TX_ON;
            next_s.rx_on      = medc_pkg::RST_RX_ON;
         end
      end

      // Indicator pin passes two flops before it is used
      next_s.dpx_sync1 = full_duplex_indicator;
      next_s.dpx_sync2 = s.dpx_sync1;

      // Polarity one means a high level is full duplex
      detected = s.dpx_pol ? s.dpx_sync2 : !s.dpx_sync2;

      // Auto detection overrides and writes back the duplex bit, winning over software
      if (next_s.auto_dpx)
      begin
         next_s.dpx_sel = detected;
      end
      next_s.full_dpx = next_s.auto_dpx ? detected : next_s.dpx_sel;

      // LPI request qualified only by the energy efficient bit, not by tx_on
      lpi_req = tx_lpi_request && s.eee_on;

      // Transmit LPI sequencer
      case (s.lpi_state)
         medc_pkg::MEDC_LPI_IDLE:
         begin
            next_s.lpi_count = '0;
            if (lpi_req)
               next_s.lpi_state = medc_pkg::MEDC_LPI_ACTIVE;
         end
         medc_pkg::MEDC_LPI_ACTIVE:
         begin
            // Delay counts from the first cycle of LPI signalling
            if (!lpi_req)
               next_s.lpi_state = medc_pkg::MEDC_LPI_IDLE;
            else if (s.auto_exit && s.lpi_count >= s.exit_delay)
               next_s.lpi_state = medc_pkg::MEDC_LPI_EXITED;
            else
               next_s.lpi_count = s.lpi_count + 1'h1;
         end
         medc_pkg::MEDC_LPI_EXITED:
         begin
            // Stays out of LPI until the request is withdrawn
            if (!lpi_req)
               next_s.lpi_state = medc_pkg::MEDC_LPI_IDLE;
         end
         default:
         begin
            next_s.lpi_state = medc_pkg::MEDC_LPI_IDLE;
         end
      endcase

      // Results registered from the next sequencer state
      next_s.tx_lpi = (next_s.lpi_state == medc_pkg::MEDC_LPI_ACTIVE);
      // Clock halt only while in LPI and never at 100 Mbps
      next_s.gtx_halt = next_s.tx_lpi && s.clk_halt && !speed_100m;
      // Receive LPI decoded even with the receiver off
      next_s.rx_lpi = rx_lpi_indication && s.eee_on;
   end

   // State register; reset loads constants only
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s            <= '0;
         s.rx_usage   <= medc_pkg::RST_USAGE;
         s.tx_usage   <= medc_pkg::RST_USAGE;
         s.clk_halt   <= medc_pkg::RST_CLK_HALT;
         s.eee_on     <= medc_pkg::RST_EEE_ON;
         s.auto_exit  <= medc_pkg::RST_AUTO_EXIT;
         s.dpx_pol    <= medc_pkg::RST_DPX_POL;
         s.auto_dpx   <= medc_pkg::RST_AUTO_DPX;
         s.dpx_sel    <= medc_pkg::RST_DPX_SEL;
         s.tx_on      <= medc_pkg::RST_TX_ON;
         s.rx_on      <= medc_pkg::RST_RX_ON;
         s.protect    <= medc_pkg::RST_PROTECT;
         s.exit_delay <= medc_pkg::RST_EXIT_DELAY;
         s.lpi_state  <= medc_pkg::MEDC_LPI_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

endmodule

`default_nettype wire

// file: verilog/medc_pkg.sv
// Package with offsets, field positions and reset values of the MAC control block
// Overview of operation
// - Rx usage upper half: out-FIFO plus frame-FIFO bytes
// - Rx usage lower half: out-FIFO bytes, reset zero
// - Tx usage upper half: in-FIFO plus frame-FIFO bytes
// - Tx usage lower half: in-FIFO bytes, reset zero
// - Clock halt enable stops transmit clock during LPI
// - Clock halt enable ignored at 100 Mbps
// - Energy efficient bit turns LPI operation on/off
// - LPI works regardless of transmitter/receiver enables
// - Auto exit drops transmit LPI after delay
// - Delay timed from LPI start, separate register
// - Polarity bit resets one, selects full-duplex level
// - Auto duplex uses indicator, writes back duplex bit
// - Without auto duplex, programmed duplex bit rules
package medc_pkg;

   // Byte addresses on the register bus
   localparam logic [11:0] ADDR_RX_USAGE    = 12'h0D4;  // rx_path_byte_usage
   localparam logic [11:0] ADDR_TX_USAGE    = 12'h0D8;  // tx_path_byte_usage
   localparam logic [11:0] ADDR_MAC_CTRL    = 12'h100;  // mac_operating_control
   localparam logic [11:0] ADDR_EXIT_DELAY  = 12'h104;  // lpi_auto_exit_delay
   localparam logic [11:0] ADDR_MISC_CTRL   = 12'h108;  // Protection and soft reset

   // Bit positions in mac_operating_control
   localparam int BIT_CLK_HALT    = 18;  // lpi_tx_clock_halt_enable
   localparam int BIT_EEE_ON      = 17;  // energy_efficient_on
   localparam int BIT_AUTO_EXIT   = 16;  // lpi_auto_exit_enable
   localparam int BIT_DPX_POL     = 13;  // duplex_indicator_polarity
   localparam int BIT_AUTO_DPX    = 12;  // Automatic duplex detection
   localparam int BIT_DPX_SEL     = 3;   // duplex_select
   localparam int BIT_TX_ON       = 1;   // transmitter_on
   localparam int BIT_RX_ON       = 0;   // receiver_on

   // Bit positions in the miscellaneous control register
   localparam int BIT_PROTECT     = 0;   // Reset protection, read/write
   localparam int BIT_SOFT_RESET  = 1;   // Write one for a soft reset, reads zero

   // Width in bits of the auto exit delay, which counts clock cycles
   localparam int DELAY_W         = 24;

   // Reset values
   localparam logic [31:0] RST_USAGE      = 32'h0000_0000;
   localparam logic        RST_CLK_HALT   = 1'h0;
   localparam logic        RST_EEE_ON     = 1'h0;
   localparam logic        RST_AUTO_EXIT  = 1'h0;
   localparam logic        RST_DPX_POL    = 1'h1;
   localparam logic        RST_AUTO_DPX   = 1'h0;
   localparam logic        RST_DPX_SEL    = 1'h0;
   localparam logic        RST_TX_ON      = 1'h0;
   localparam logic        RST_RX_ON      = 1'h0;
   localparam logic        RST_PROTECT    = 1'h0;
   localparam logic [23:0] RST_EXIT_DELAY = 24'h00_0000;

   // Transmit LPI sequencing, one-hot
   typedef enum logic [2:0]
   {
      MEDC_LPI_IDLE   = 3'h1,   // No LPI requested
      MEDC_LPI_ACTIVE = 3'h2,   // LPI signalled toward the PHY
      MEDC_LPI_EXITED = 3'h4    // Auto exit fired, waiting for request to drop
   } medc_lpi_t;

endpackage

// file: dv/medc_phy_model.sv
// Behavioural PHY side: duplex indicator pin and receive LPI indication
`timescale 1ns/1ps
`default_nettype none
module medc_phy_model
(
   input  wire logic clk,                   // System clock
   input  wire logic link_full,             // Duplex the PHY negotiated
   input  wire logic lvl_high_full,         // Pin level that means full duplex
   input  wire logic lpi_rx,                // Link partner sits in LPI
   output logic      full_duplex_indicator, // Duplex pin toward the MAC
   output logic      rx_lpi_indication      // Decoded LPI toward the MAC
);
   // Pins move just after the edge, as real PHY outputs do
   always_ff @(posedge clk)
   begin
      full_duplex_indicator <= lvl_high_full ? link_full : !link_full;
      rx_lpi_indication     <= lpi_rx;
   end
endmodule
`default_nettype wire

// file: dv/medc_ctrl_properties.sv
// Port-level checks of the MAC control block
`timescale 1ns/1ps
`default_nettype none
module medc_ctrl_properties
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        speed_100m,
   input wire logic        tx_lpi_request,
   input wire logic        rx_lpi_indication,
   input wire logic        tx_lpi_active,
   input wire logic        gtx_clk_halt,
   input wire logic        rx_lpi_seen,
   input wire logic        transmitter_on
);
   // One clock domain, so one default clock and disable
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_cause: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_halt_speed: assert property ($past(speed_100m) |-> !gtx_clk_halt)
      else $error("clock halted at 100 Mbps");
   a_halt_lpi: assert property (gtx_clk_halt |-> tx_lpi_active)
      else $error("clock halted outside LPI");
   a_lpi_cause: assert property (!$past(tx_lpi_request) |-> !tx_lpi_active)
      else $error("LPI without request");
   a_rx_lpi: assert property (rx_lpi_seen |-> $past(rx_lpi_indication))
      else $error("receive LPI without indication");
   a_txon_write: assert property ($changed(transmitter_on) |-> wb_ack_o || $past(wb_ack_o))
      else $error("transmitter enable moved without a write");
   // Main scenarios reached
   c_halt: cover property (gtx_clk_halt);
   c_exit: cover property ($fell(tx_lpi_active) && tx_lpi_request);
   c_rx_lpi: cover property (rx_lpi_seen);
endmodule
`default_nettype wire

// file: dv/tb_medc_ctrl.sv
// Self-checking bench for the MAC control block
`timescale 1ns/1ps
`default_nettype none
module tb_medc_ctrl;
   logic        clk, rst_n, cyc, stb, we, ack;    // Clock, reset, bus handshake
   logic [11:0] adr;                              // Bus address
   logic [3:0]  sel;                              // Byte lanes
   logic [31:0] wdat, rdat, q;                    // Write, read and captured data
   logic [15:0] uo, rf, ui, tf;                   // FIFO byte counts
   logic        spd, req, full, phi, lpi, ind, rxi; // MAC and PHY side stimulus
   logic        fd, lact, halt, rseen, ton, ron;  // Results
   int          error_cnt, num_checks, n, cnt;    // Tallies and loop counts

   always #50 clk = ~clk;

   medc_ctrl u_medc_ctrl (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .usb_out_fifo_bytes(uo), .rx_frame_fifo_bytes(rf),
      .usb_in_fifo_bytes(ui), .tx_frame_fifo_bytes(tf), .speed_100m(spd),
      .tx_lpi_request(req), .rx_lpi_indication(rxi), .full_duplex_indicator(ind),
      .full_duplex(fd), .tx_lpi_active(lact), .gtx_clk_halt(halt), .rx_lpi_seen(rseen),
      .transmitter_on(ton), .receiver_on(ron));
   medc_phy_model u_medc_phy_model (.clk(clk), .link_full(full), .lvl_high_full(phi),
      .lpi_rx(lpi), .full_duplex_indicator(ind), .rx_lpi_indication(rxi));

   // Verdict and end of run
   task automatic stop_test();
      if (error_cnt == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Classic cycle; ack and read data taken at the rising edge, request dropped at that edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      // Values read here are those held just before the edge, as the slave sees them
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         error_cnt++;
         $display("Error %0t: no ack", $time);
         stop_test();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      // One idle cycle so the next request is never taken twice
      @(posedge clk);
   endtask

   // Register value compare
   task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      num_checks++;
      if (q !== e)
      begin
         error_cnt++;
         $display("Error %0t: reg %h read %h not %h", $time, a, q, e);
      end
   endtask

   // Single-bit compare, taken at the moment of the call, with no wait of its own
   task automatic chk_bit(input logic v, input logic e, input string s);
      num_checks++;
      if (v !== e)
      begin
         error_cnt++;
         $display("Error %0t: %s is %b", $time, s, v);
      end
   endtask

   initial
   begin
      {clk, rst_n, cyc, stb, we, spd, req, full, lpi} = '0;
      {adr, wdat, uo, rf, ui, tf} = '0;
      sel = 4'hF;
      phi = 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk_reg(medc_pkg::ADDR_RX_USAGE, 32'h0);
      chk_reg(medc_pkg::ADDR_TX_USAGE, 32'h0);
      chk_reg(medc_pkg::ADDR_MAC_CTRL, 32'h0000_2000);
      // Counts chosen so the receive total wraps
      {uo, rf, ui, tf} <= {16'hFFF0, 16'h0020, 16'h1234, 16'h0100};
      bus(1'b1, medc_pkg::ADDR_RX_USAGE, 32'hFFFF_FFFF);
      chk_reg(medc_pkg::ADDR_RX_USAGE, 32'h0010_FFF0);
      chk_reg(medc_pkg::ADDR_TX_USAGE, 32'h1334_1234);
      chk_reg(12'h0F0, 32'h0);
      bus(1'b1, medc_pkg::ADDR_MAC_CTRL, 32'hFFFF_EFFF);
      chk_reg(medc_pkg::ADDR_MAC_CTRL, 32'h0007_200B);
      chk_bit(fd & ton & ron, 1'b1, "duplex and enables");
      // LPI with transmitter and receiver both off
      // The modelled PHY tolerates a stopped clock, so the halt enable may be set
      bus(1'b1, medc_pkg::ADDR_MAC_CTRL, 32'h0006_2000);
      chk_bit(fd, 1'b0, "duplex");
      {req, lpi} <= 2'h3;
      repeat (4) @(negedge clk);
      chk_bit(lact & halt & rseen, 1'b1, "lpi state");
      @(posedge clk);
      spd <= 1'b1;
      repeat (2) @(negedge clk);
      chk_bit(halt, 1'b0, "clock halt");
      bus(1'b1, medc_pkg::ADDR_MAC_CTRL, 32'h0004_2000);
      chk_bit(lact | rseen, 1'b0, "lpi off");
      // Auto exit, enabled while the feature is off
      {req, spd} <= 2'h0;
      bus(1'b1, medc_pkg::ADDR_EXIT_DELAY, 32'h0000_0005);
      bus(1'b1, medc_pkg::ADDR_MAC_CTRL, 32'h0001_2000);
      bus(1'b1, medc_pkg::ADDR_MAC_CTRL, 32'h0003_2000);
      req <= 1'b1;
      cnt = 0;
      repeat (30)
      begin
         @(negedge clk);
         cnt += int'(lact === 1'b1);
      end
      chk_bit(cnt == 6, 1'b1, "lpi length");
      @(posedge clk);
      req <= 1'b0;
      // Auto duplex over both polarities and both modes, enables kept off
      for (int p = 0; p < 2; p++)
      begin
         bus(1'b1, medc_pkg::ADDR_MAC_CTRL, 32'h0000_1000 | (p << 13));
         for (int f = 0; f < 2; f++)
         begin
            {phi, full} <= {p[0], f[0]};
            repeat (6) @(negedge clk);
            chk_bit(fd, f[0], "detected duplex");
            chk_reg(medc_pkg::ADDR_MAC_CTRL, 32'h0000_1000 | (p << 13) | (f << 3));
         end
      end
      // Soft reset with protection held, then without
      bus(1'b1, medc_pkg::ADDR_MAC_CTRL, 32'h0007_3003);
      bus(1'b1, medc_pkg::ADDR_MISC_CTRL, 32'h1);
      bus(1'b1, medc_pkg::ADDR_MISC_CTRL, 32'h2);
      chk_reg(medc_pkg::ADDR_MAC_CTRL, 32'h0007_300B);
      bus(1'b1, medc_pkg::ADDR_MISC_CTRL, 32'h2);
      chk_reg(medc_pkg::ADDR_MAC_CTRL, 32'h0000_2000);
      stop_test();
   end
endmodule

bind medc_ctrl medc_ctrl_properties u_medc_ctrl_properties (.clk(clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .speed_100m(speed_100m), .tx_lpi_request(tx_lpi_request),
   .rx_lpi_indication(rx_lpi_indication), .tx_lpi_active(tx_lpi_active),
   .gtx_clk_halt(gtx_clk_halt), .rx_lpi_seen(rx_lpi_seen), .transmitter_on(transmitter_on));
`default_nettype wire
